// file: core/vipn_core.sv
// Purpose: Priority, nesting and vector logic of the interrupt controller
// Assumes: Source request lines are already masked and synchronous to clk
// Notes:   Vector base arrives as a port from the base register outside
`timescale 1ns/1ps
`include "vipn_defs.svh"

// Overview of operation
// RULE1: Timer and software levels in first register
// RULE2: Source zero has no level field
// RULE3: Serial and external levels in second register
// RULE4: Slave and external levels in third register
// RULE5: Level zero most urgent, seven least
// RULE6: Control bit0 nests IRQ, bit1 nests FIQ
// RULE7: Nesting off: deliver, no levels, FIQ first
// RULE8: IRQ vector read pushes its level bit
// RULE9: FIQ vector read pushes its level bit
// RULE10: Stacked level blocks equal or lower levels
// RULE11: Stack write clears lowest set bit only
// RULE12: FIQ vector: base 22:7, source 6:2
// RULE13: Timer one encodes as 01000
// RULE14: IRQ vector uses the same layout
// RULE15: Software reads FIQ vector only when servicing
// RULE16: Software writes zero to reserved bits
// RULE17: Ties go to lowest source; reserved read zero
module vipn_core (
  input  wire logic                 clk,         // 200 MHz system clock
  input  wire logic                 rstn,        // Synchronous reset, low
  input  wire vipn_pkg::vipn_bus_s  bus,         // Register port request
  output logic [31:0]               rdata,       // Read data, cycle after
  input  wire vipn_pkg::vipn_srcvec_t irq_src,   // Active IRQ sources
  input  wire vipn_pkg::vipn_srcvec_t fiq_src,   // Active FIQ sources
  input  wire logic [15:0]          vec_base,    // Vector table base
  output logic                      irq_req,     // IRQ request to core
  output logic                      fiq_req,     // FIQ request to core
  output logic                      int_out      // Event interrupt
);
  import vipn_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] prio0_reg;                        // Timers and software
  logic [31:0] prio1_reg;                        // Serial and external
  logic [31:0] prio2_reg;                        // Slaves and external
  logic [1:0]  conn_reg;                         // Nesting enables
  logic [7:0]  nstack_reg;                       // Normal priority stack
  logic [7:0]  fstack_reg;                       // Fast priority stack
  logic [2:0]  evstat_reg;                       // Sticky event bits
  logic [2:0]  evmask_reg;                       // Event enables
  logic [31:0] rdata_reg;                        // Read data holding
  logic        irq_req_reg;                      // IRQ line flop
  logic        fiq_req_reg;                      // FIQ line flop
  logic        int_reg;                          // Event line flop

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire hit_p0  = (bus.addr == `VIPN_ADDR_PRIO0);
  wire hit_p1  = (bus.addr == `VIPN_ADDR_PRIO1);
  wire hit_p2  = (bus.addr == `VIPN_ADDR_PRIO2);
  wire hit_cn  = (bus.addr == `VIPN_ADDR_CONN);
  wire hit_ns  = (bus.addr == `VIPN_ADDR_NSTACK);
  wire hit_fs  = (bus.addr == `VIPN_ADDR_FSTACK);
  wire hit_nv  = (bus.addr == `VIPN_ADDR_NVEC);
  wire hit_fv  = (bus.addr == `VIPN_ADDR_FVEC);
  wire hit_es  = (bus.addr == `VIPN_ADDR_EVSTAT);
  wire hit_em  = (bus.addr == `VIPN_ADDR_EVMASK);

  wire nest_n  = conn_reg[`VIPN_CONN_NORMAL];    // RULE6
  wire nest_f  = conn_reg[`VIPN_CONN_FAST];      // RULE6

  // ****************************************************************
  // Per-source levels
  // ****************************************************************
  // Source zero is fixed most urgent; unused numbers sit least urgent
  logic [2:0] lvl [0:19];                        // Level of each source
  assign lvl[0]  = 3'h0;                                     // RULE2
  assign lvl[1]  = prio0_reg[`VIPN_LSB_SWI +: 3];            // RULE1
  assign lvl[2]  = prio1_reg[`VIPN_LSB_EXT0 +: 3];           // RULE3
  assign lvl[3]  = prio1_reg[`VIPN_LSB_EXT1 +: 3];           // RULE3
  assign lvl[4]  = prio2_reg[`VIPN_LSB_EXT2 +: 3];           // RULE4
  assign lvl[5]  = prio2_reg[`VIPN_LSB_EXT3 +: 3];           // RULE4
  assign lvl[6]  = 3'h7;
  assign lvl[7]  = prio0_reg[`VIPN_LSB_T0 +: 3];             // RULE1
  assign lvl[8]  = prio0_reg[`VIPN_LSB_T1 +: 3];             // RULE1 RULE13
  assign lvl[9]  = prio0_reg[`VIPN_LSB_T2 +: 3];             // RULE1
  assign lvl[10] = prio0_reg[`VIPN_LSB_T3 +: 3];             // RULE1
  assign lvl[11] = prio1_reg[`VIPN_LSB_ADC +: 3];            // RULE3
  assign lvl[12] = prio1_reg[`VIPN_LSB_UART +: 3];           // RULE3
  assign lvl[13] = prio1_reg[`VIPN_LSB_SPIC +: 3];           // RULE3
  assign lvl[14] = prio2_reg[`VIPN_LSB_SPIT +: 3];           // RULE4
  assign lvl[15] = prio1_reg[`VIPN_LSB_I2CC +: 3];           // RULE3
  assign lvl[16] = prio2_reg[`VIPN_LSB_I2CT +: 3];           // RULE4
  assign lvl[17] = 3'h7;
  assign lvl[18] = 3'h7;
  assign lvl[19] = 3'h7;

  // ****************************************************************
  // Priority search chains
  // ****************************************************************
  // Ascending scan with strict compare keeps the lowest number on ties
  vipn_pick_s nchain [0:20];                     // Normal search stages
  vipn_pick_s fchain [0:20];                     // Fast search stages
  assign nchain[0] = '0;
  assign fchain[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_pick
      // Level used for comparison; all equal when nesting is off
      wire [2:0] nl = nest_n ? lvl[gi] : 3'h0;              // RULE7
      wire [2:0] fl = nest_f ? lvl[gi] : 3'h0;              // RULE7
      // Stack bits at this level or more urgent block the source
      wire [7:0] upto = 8'((9'h002 << lvl[gi]) - 9'h001);
      wire nblk = nest_n && |(nstack_reg & upto);           // RULE10
      wire fblk = nest_f && |(fstack_reg & upto);           // RULE10
      wire nok  = irq_src[gi] && !nblk;
      wire fok  = fiq_src[gi] && !fblk;
      wire nwin = nok && (!nchain[gi].valid || nl < nchain[gi].level); // RULE5 RULE17
      wire fwin = fok && (!fchain[gi].valid || fl < fchain[gi].level); // RULE5 RULE17
      assign nchain[gi+1] = nwin ? vipn_pick_s'{1'b1, nl, 5'(gi)} : nchain[gi];
      assign fchain[gi+1] = fwin ? vipn_pick_s'{1'b1, fl, 5'(gi)} : fchain[gi];
    end
  endgenerate

  wire vipn_pick_s npick = nchain[20];           // Most urgent IRQ
  wire vipn_pick_s fpick = fchain[20];           // Most urgent FIQ

  // ****************************************************************
  // Vector words
  // ****************************************************************
  wire [31:0] nvec = {9'h000, vec_base, npick.num, 2'h0};   // RULE14 RULE13
  wire [31:0] fvec = {9'h000, vec_base, fpick.num, 2'h0};   // RULE12 RULE13

  // ****************************************************************
  // Stack update
  // ****************************************************************
  // Vector read with nesting on pushes the winner's level; it is the software's job
  // to read only while servicing, as the read has this side effect
  wire npush = bus.rd && hit_nv && nest_n && npick.valid;   // RULE8 RULE15
  wire fpush = bus.rd && hit_fv && nest_f && fpick.valid;   // RULE9 RULE15
  wire [7:0] nlow = nstack_reg & 8'(~nstack_reg + 8'h01);   // Lowest set bit
  wire [7:0] flow = fstack_reg & 8'(~fstack_reg + 8'h01);
  wire npop = bus.wr && hit_ns && |(nlow & bus.wdata[7:0]);
  wire fpop = bus.wr && hit_fs && |(flow & bus.wdata[7:0]);

  wire [7:0] nstack_next = npush ? (nstack_reg | (8'h01 << npick.level))
                         : npop  ? (nstack_reg & ~nlow)     // RULE11
                         : nstack_reg;
  wire [7:0] fstack_next = fpush ? (fstack_reg | (8'h01 << fpick.level))
                         : fpop  ? (fstack_reg & ~flow)     // RULE11
                         : fstack_reg;

  // ****************************************************************
  // Events
  // ****************************************************************
  wire [2:0] ev_set = {npop | fpop, fpush, npush};
  wire [2:0] ev_clr = (bus.wr && hit_es) ? bus.wdata[2:0] : 3'h0;
  // Set wins over clear in the same cycle
  wire [2:0] evstat_next = (evstat_reg & ~ev_clr) | ev_set;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reserved bits and unmapped addresses read zero
  wire [31:0] rd_mux =
      hit_p0 ? prio0_reg :                                  // RULE2
      hit_p1 ? prio1_reg :
      hit_p2 ? prio2_reg :
      hit_cn ? {30'h0, conn_reg} :                          // RULE17
      hit_ns ? {24'h0, nstack_reg} :
      hit_fs ? {24'h0, fstack_reg} :
      hit_nv ? nvec :
      hit_fv ? fvec :
      hit_es ? {29'h0, evstat_reg} :
      hit_em ? {29'h0, evmask_reg} : `VIPN_RST_WORD;
  wire [31:0] rdata_next = bus.rd ? rd_mux : `VIPN_RST_WORD;

  // ****************************************************************
  // Request lines
  // ****************************************************************
  // With IRQ nesting off a pending FIQ holds IRQ back
  wire irq_next = npick.valid && (nest_n || !fpick.valid);  // RULE7
  wire fiq_next = fpick.valid;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Reserved bits are masked so stray writes cannot set them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prio0_reg <= `VIPN_RST_WORD;
      prio1_reg <= `VIPN_RST_WORD;
      prio2_reg <= `VIPN_RST_WORD;
      conn_reg  <= 2'h0;
      evmask_reg <= `VIPN_RST_EV;
    end else begin
      if (bus.wr && hit_p0) prio0_reg <= bus.wdata & `VIPN_MASK_PRIO0; // RULE1 RULE2
      if (bus.wr && hit_p1) prio1_reg <= bus.wdata & `VIPN_MASK_PRIO1; // RULE3
      if (bus.wr && hit_p2) prio2_reg <= bus.wdata & `VIPN_MASK_PRIO2; // RULE4
      if (bus.wr && hit_cn) conn_reg  <= bus.wdata[1:0];               // RULE6 RULE16
      if (bus.wr && hit_em) evmask_reg <= bus.wdata[2:0];
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nstack_reg  <= `VIPN_RST_STACK;
      fstack_reg  <= `VIPN_RST_STACK;
      evstat_reg  <= `VIPN_RST_EV;
      rdata_reg   <= `VIPN_RST_WORD;
      irq_req_reg <= 1'b0;
      fiq_req_reg <= 1'b0;
      int_reg     <= 1'b0;
    end else begin
      nstack_reg  <= nstack_next;
      fstack_reg  <= fstack_next;
      evstat_reg  <= evstat_next;
      rdata_reg   <= rdata_next;
      irq_req_reg <= irq_next;
      fiq_req_reg <= fiq_next;
      int_reg     <= |(evstat_next & evmask_reg);
    end
  end

  assign rdata   = rdata_reg;
  assign irq_req = irq_req_reg;
  assign fiq_req = fiq_req_reg;
  assign int_out = int_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Normal vector read with nesting pushes the winner's level bit
  AST_NPUSH: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    npush |=> nstack_reg[$past(npick.level)])
    else $error("normal stack bit not set after vector read");

  // Fast vector read with nesting pushes the winner's level bit
  AST_FPUSH: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    fpush |=> fstack_reg[$past(fpick.level)])
    else $error("fast stack bit not set after vector read");

  // A stack write removes at most one bit, the lowest
  AST_POP_ONE: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    (bus.wr && hit_ns && nstack_reg == 8'h09 && bus.wdata[7:0] == 8'hFF)
      |=> nstack_reg == 8'h08)
    else $error("stack write did not clear only the lowest bit");

  // Fast vector read shows base and source in place, zero elsewhere
  AST_FVEC: assert property (@(posedge clk) disable iff (!rstn) // RULE12
    (bus.rd && hit_fv) |=> (rdata[31:23] == 9'h000 && rdata[1:0] == 2'h0
      && rdata[22:7] == $past(vec_base) && rdata[6:2] == $past(fpick.num)))
    else $error("fast vector layout wrong");

  // No winning normal source is blocked by its own or a higher level
  AST_BLOCK: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (nest_n && npick.valid)
      |-> (nstack_reg & 8'((9'h002 << npick.level) - 9'h001)) == 8'h00)
    else $error("blocked level passed the stack");

  // Without IRQ nesting a pending FIQ keeps IRQ low next cycle
  AST_FIQ_FIRST: assert property (@(posedge clk) disable iff (!rstn) // RULE7
    (!nest_n && fpick.valid) |=> (!irq_req && fiq_req))
    else $error("IRQ raised beside FIQ with nesting off");

  // Bits 3:0 of the first level register always read zero
  AST_SRC0: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    (bus.rd && hit_p0) |=> rdata[3:0] == 4'h0)
    else $error("source zero level bits not zero");

  // Reserved control bits read zero
  AST_CONN_RSV: assert property (@(posedge clk) disable iff (!rstn) // RULE17
    (bus.rd && hit_cn) |=> rdata[31:2] == 30'h0)
    else $error("reserved control bits not zero");

  // Two fast timer sources at one level never resolve to the higher number
  AST_TIE: assert property (@(posedge clk) disable iff (!rstn) // RULE17
    (fiq_src[7] && fiq_src[8] && lvl[7] == lvl[8]) |-> fpick.num != 5'h08)
    else $error("tie not resolved to lowest source");

  // Interrupt line follows masked next status one cycle later
  AST_INT: assert property (@(posedge clk) disable iff (!rstn)
    ##1 int_out == |($past(evstat_next) & $past(evmask_reg)))
    else $error("interrupt output does not follow status");

endmodule // vipn_core

// file: core/vipn_defs.svh
// Purpose: Offsets, field positions, reset values, nesting and event bits
// Assumes: Byte addresses on a 32-bit register port
// Notes:   Definitions only
`ifndef VIPN_DEFS_SVH
`define VIPN_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define VIPN_ADDR_PRIO0     32'hFFFF0020
`define VIPN_ADDR_PRIO1     32'hFFFF0024
`define VIPN_ADDR_PRIO2     32'hFFFF0028
`define VIPN_ADDR_CONN      32'hFFFF0030
`define VIPN_ADDR_NSTACK    32'hFFFF003C
`define VIPN_ADDR_NVEC      32'hFFFF001C
`define VIPN_ADDR_FVEC      32'hFFFF011C
`define VIPN_ADDR_FSTACK    32'hFFFF013C
`define VIPN_ADDR_EVSTAT    32'hFFFF0040
`define VIPN_ADDR_EVMASK    32'hFFFF0044

// ****************************************************************
// Writable bits and reset values
// ****************************************************************
`define VIPN_MASK_PRIO0     32'h07777070
`define VIPN_MASK_PRIO1     32'h77777700
`define VIPN_MASK_PRIO2     32'h00007777
`define VIPN_MASK_CONN      32'h00000003
`define VIPN_RST_WORD       32'h00000000
`define VIPN_RST_STACK      8'h00
`define VIPN_RST_EV         3'h0

// ****************************************************************
// Level field positions (low bit of each 3-bit field)
// ****************************************************************
`define VIPN_LSB_T3         24
`define VIPN_LSB_T2         20
`define VIPN_LSB_T1         16
`define VIPN_LSB_T0         12
`define VIPN_LSB_SWI        4
`define VIPN_LSB_I2CC       28
`define VIPN_LSB_EXT1       24
`define VIPN_LSB_EXT0       20
`define VIPN_LSB_SPIC       16
`define VIPN_LSB_UART       12
`define VIPN_LSB_ADC        8
`define VIPN_LSB_EXT3       12
`define VIPN_LSB_EXT2       8
`define VIPN_LSB_SPIT       4
`define VIPN_LSB_I2CT       0

// ****************************************************************
// Nesting control bits and event bits
// ****************************************************************
`define VIPN_CONN_NORMAL    0
`define VIPN_CONN_FAST      1
`define VIPN_EV_NPUSH       0
`define VIPN_EV_FPUSH       1
`define VIPN_EV_POP         2

`endif

// file: core/vipn_pkg.sv
// Purpose: Shared types of the priority and nesting block
// Assumes: Constants live in vipn_defs.svh
// Notes:   Source numbers double as the vector source field
package vipn_pkg;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vipn_bus_s;

  // Winner of a priority search
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [4:0] num;
  } vipn_pick_s;

  // Source numbers; timer one sits at 01000
  typedef enum logic [4:0] {
    VIPN_S_ZERO = 5'h00, VIPN_S_SWI  = 5'h01, VIPN_S_EXT0 = 5'h02,
    VIPN_S_EXT1 = 5'h03, VIPN_S_EXT2 = 5'h04, VIPN_S_EXT3 = 5'h05,
    VIPN_S_T0   = 5'h07, VIPN_S_T1   = 5'h08, VIPN_S_T2   = 5'h09,
    VIPN_S_T3   = 5'h0A, VIPN_S_ADC  = 5'h0B, VIPN_S_UART = 5'h0C,
    VIPN_S_SPIC = 5'h0D, VIPN_S_SPIT = 5'h0E, VIPN_S_I2CC = 5'h0F,
    VIPN_S_I2CT = 5'h10
  } vipn_src_e;

  typedef logic [19:0] vipn_srcvec_t;

endpackage

// file: test/tb_vipn_core.sv
// Purpose: Self-checking bench of the priority and nesting block
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Sources are driven directly; no random stimulus
`timescale 1ns/1ps
`include "vipn_defs.svh"

module tb_vipn_core;
  import vipn_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic         clk;        // 200 MHz
  logic         rstn;       // Synchronous reset, low
  vipn_bus_s    bus;        // Register port request
  logic [31:0]  rdata;      // Read data
  vipn_srcvec_t irq_src;    // Normal sources
  vipn_srcvec_t fiq_src;    // Fast sources
  logic [15:0]  vec_base;   // Vector base
  logic         irq_req;    // Normal request
  logic         fiq_req;    // Fast request
  logic         int_out;    // Event interrupt
  logic         irq_seen;   // Core entered normal
  logic         fiq_seen;   // Core entered fast
  logic         seen_clr;   // Core model clear
  int           n_mismatch; // Failed compares
  int           n_compared; // All compares
  int           cyc = 0;    // Timeout counter, driven by the hang guard only
  logic [31:0]  regs [9];   // Reset table, last one unmapped

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  vipn_core dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .irq_src(irq_src),
    .fiq_src(fiq_src), .vec_base(vec_base), .irq_req(irq_req), .fiq_req(fiq_req),
    .int_out(int_out));
  vipn_core_model core (.clk(clk), .rstn(rstn), .irq_req(irq_req), .fiq_req(fiq_req),
    .seen_clr(seen_clr), .irq_seen(irq_seen), .fiq_seen(fiq_seen));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Let registered requests settle before they are looked at
  task automatic reqs(input logic ei, input logic ef);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq_req}, {31'h0, ei});
    chk({31'h0, fiq_req}, {31'h0, ef});
  endtask

  task automatic src(input vipn_srcvec_t i, input vipn_srcvec_t f);
    @(posedge clk);
    irq_src <= i;
    fiq_src <= f;
  endtask

  // Vector word: zero top, base at 22:7, source at 6:2, zero bottom
  function automatic logic [31:0] vec(input logic [4:0] num);
    return {9'h0, vec_base, num, 2'b00};
  endfunction

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rstn = 1'b0; bus = '0; irq_src = '0; fiq_src = '0; seen_clr = 1'b0;
    vec_base = 16'h0000; n_mismatch = 0; n_compared = 0;
    regs = '{`VIPN_ADDR_PRIO0, `VIPN_ADDR_PRIO1, `VIPN_ADDR_PRIO2, `VIPN_ADDR_CONN,
      `VIPN_ADDR_NSTACK, `VIPN_ADDR_FSTACK, `VIPN_ADDR_NVEC, `VIPN_ADDR_FVEC, 32'hFFFF0050};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0);
    // Base stays zero until the reset table has been read
    vec_base <= 16'hA5C3;
    $display("test reset done");
    // Reserved level bits read zero; writes one idle cycle apart
    wr(`VIPN_ADDR_PRIO0, 32'hFFFFFFFF);
    wr(`VIPN_ADDR_PRIO1, 32'hFFFFFFFF);
    wr(`VIPN_ADDR_PRIO2, 32'hFFFFFFFF);
    rd(`VIPN_ADDR_PRIO0, 32'h07777070);
    rd(`VIPN_ADDR_PRIO0, 32'h07777070);
    rd(`VIPN_ADDR_PRIO1, 32'h77777700);
    rd(`VIPN_ADDR_PRIO2, 32'h00007777);
    $display("test levels done");
    // Nesting off: levels ignored, lowest number wins, fast first
    wr(`VIPN_ADDR_PRIO0, 32'h00070000);
    wr(`VIPN_ADDR_PRIO1, 32'h00003000);
    wr(`VIPN_ADDR_PRIO2, 32'h0);
    src(20'h01100, 20'h0);
    reqs(1'b1, 1'b0);
    rd(`VIPN_ADDR_NVEC, vec(5'b01000));
    rd(`VIPN_ADDR_NVEC, vec(5'd8));
    rd(`VIPN_ADDR_NSTACK, 32'h0);
    src(20'h01100, 20'h01000);
    reqs(1'b0, 1'b1);
    rd(`VIPN_ADDR_FVEC, vec(5'd12));
    rd(`VIPN_ADDR_FSTACK, 32'h0);
    $display("test default done");
    // Normal nesting on; reserved control bits written as zero
    src(20'h01100, 20'h0);
    wr(`VIPN_ADDR_CONN, 32'h00000001);
    wr(`VIPN_ADDR_PRIO0, 32'h00050000);
    wr(`VIPN_ADDR_EVMASK, 32'h7);
    reqs(1'b1, 1'b0);
    rd(`VIPN_ADDR_NVEC, vec(5'd12));
    rd(`VIPN_ADDR_NSTACK, 32'h08);
    reqs(1'b0, 1'b0);
    chk({31'h0, int_out}, 32'h1);
    src(20'h01101, 20'h0);
    reqs(1'b1, 1'b0);
    rd(`VIPN_ADDR_NVEC, vec(5'd0));
    rd(`VIPN_ADDR_NSTACK, 32'h09);
    wr(`VIPN_ADDR_NSTACK, 32'h00);
    rd(`VIPN_ADDR_NSTACK, 32'h09);
    wr(`VIPN_ADDR_NSTACK, 32'hFF);
    rd(`VIPN_ADDR_NSTACK, 32'h08);
    wr(`VIPN_ADDR_NSTACK, 32'hFF);
    rd(`VIPN_ADDR_NSTACK, 32'h00);
    reqs(1'b1, 1'b0);
    $display("test normal nesting done");
    // Events: sticky status, mask, write-one clear
    rd(`VIPN_ADDR_EVSTAT, 32'h5);
    wr(`VIPN_ADDR_EVMASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, int_out}, 32'h0);
    wr(`VIPN_ADDR_EVMASK, 32'h4);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, int_out}, 32'h1);
    wr(`VIPN_ADDR_EVSTAT, 32'h7);
    rd(`VIPN_ADDR_EVSTAT, 32'h0);
    chk({31'h0, int_out}, 32'h0);
    $display("test events done");
    // Fast nesting on; tie at one level goes to the lower number
    src(20'h0, 20'h00180);
    // Clear only once the last normal request has left the line
    seen_clr <= 1'b1;
    wr(`VIPN_ADDR_CONN, 32'h00000002);
    seen_clr <= 1'b0;
    wr(`VIPN_ADDR_PRIO0, 32'h00055000);
    reqs(1'b0, 1'b1);
    rd(`VIPN_ADDR_FVEC, vec(5'd7));
    rd(`VIPN_ADDR_FVEC, vec(5'd0));
    rd(`VIPN_ADDR_FSTACK, 32'h20);
    rd(`VIPN_ADDR_NSTACK, 32'h0);
    reqs(1'b0, 1'b0);
    rd(`VIPN_ADDR_EVSTAT, 32'h2);
    chk({31'h0, fiq_seen}, 32'h1);
    chk({31'h0, irq_seen}, 32'h0);
    $display("test fast nesting done");
    results();
  end
endmodule // tb_vipn_core

// file: test/vipn_core_model.sv
// Purpose: Behavioural processor core on the far side of the request lines
// Assumes: irq_req and fiq_req are level requests, synchronous to clk
// Notes:   Records which request class the core would have entered
`timescale 1ns/1ps

// ****************************************************************
// Core model
// ****************************************************************
module vipn_core_model (
  input  wire logic clk,       // System clock
  input  wire logic rstn,      // Synchronous reset, low
  input  wire logic irq_req,   // Normal request from the controller
  input  wire logic fiq_req,   // Fast request from the controller
  input  wire logic seen_clr,  // Forget what was seen
  output logic      irq_seen,  // Normal exception entered
  output logic      fiq_seen   // Fast exception entered
);
  // Fast entry wins over normal entry in the same cycle, as a real core does
  always_ff @(posedge clk) begin
    if (!rstn || seen_clr) begin
      irq_seen <= 1'b0;
      fiq_seen <= 1'b0;
    end else begin
      if (fiq_req) fiq_seen <= 1'b1;
      if (irq_req && !fiq_req) irq_seen <= 1'b1;
    end
  end
endmodule // vipn_core_model
